// *** tlb_top.sv ***
// Loopback path selector for one transceiver channel with APB control
// Summary of operation
// - Serial loopback unavailable in PCIe configuration
// - Serial loopback switchable per channel at run time
// - Serial loopback feeds transmit into clock recovery
// - Serial output keeps driving during serial loopback
// - Forward parallel loopback selectable only in generic configuration
// - Forward parallel loopback via pattern test mode
// - Pattern passes aligner into verifier, status visible
// - Rate-match output drives serializer in reverse parallel
// - Received data still delivered to fabric
// - Detect/loopback input selects reverse parallel loopback in PCIe configuration
// - PCIe supports only reverse parallel loopback
// - Reverse serial retimes input onto serial output
// - Reverse serial selected by registers only
// - Reverse serial: swing and pre-emphasis changeable
// - Pre-recovery loopback returns raw serial input
// - Pre-recovery loopback: swing only, pre-emphasis fixed
// - Loopback other than reverse parallel enabled by management bus register writes
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module tlb_top
	import tlb_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Fabric transmit side
	input wire logic [TLB_DATA_W-1:0] tx_parallel_data,
	input wire logic pipe_detect_loopback,
	input wire logic rx_pcs_reset,
	// Fabric receive side
	output logic [TLB_DATA_W-1:0] rx_parallel_data,
	output logic rx_data_valid,
	output logic rx_pcs_in_reset,
	// Serial pins, one bit per word slot
	input wire logic [TLB_DATA_W-1:0] rx_serial_data,
	output logic [TLB_DATA_W-1:0] tx_serial_data,
	// Transmit buffer analog settings
	output logic [TLB_SWING_W-1:0] output_swing_setting,
	output logic [TLB_PRE_W-1:0] tx_pre_emphasis
);

	// ****************************************
	// Registers
	// ****************************************

	// Channel configuration and PCIe second generation flag
	logic [1:0] cfg_reg;
	logic gen2_reg;
	// Selected loopback mode
	logic [TLB_MODE_W-1:0] mode_reg;
	// Analog settings
	tlb_analog_t analog_reg;
	// Mode change reset counter
	logic [2:0] rst_cnt_reg;
	// Previous effective mode
	logic [TLB_MODE_W-1:0] eff_prev_reg;
	// Pipeline stages
	tlb_word_t cdr_reg;
	tlb_word_t rm_reg;
	logic [TLB_DATA_W-1:0] tx_word_reg;

	// Effective mode after qualification
	logic [TLB_MODE_W-1:0] eff_mode;
	logic pcie_cfg;
	logic prbs_en;
	logic [TLB_DATA_W-1:0] prbs_data;
	logic prbs_locked;
	logic prbs_error;
	logic apb_wr;
	logic apb_rd;
	logic [TLB_MODE_W-1:0] wmode;
	logic mode_ok;
	logic pcs_rst;

	assign pcie_cfg = (cfg_reg == TLB_CFG_PCIE);
	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & penable & ~pwrite;
	assign wmode = pwdata[TLB_MODE_W-1:0];

	// ****************************************
	// Mode qualification
	// ****************************************

	// Legal register modes per configuration
	always_comb
	begin
		mode_ok = 1'b0;
		unique case (wmode)
			TLB_LB_SERIAL: mode_ok = ~pcie_cfg;
			TLB_LB_FWD_PAR: mode_ok = (cfg_reg == TLB_CFG_GENERIC);
			TLB_LB_REV_SER: mode_ok = ~pcie_cfg;
			TLB_LB_REV_PRE: mode_ok = ~pcie_cfg;
			TLB_LB_NONE: mode_ok = 1'b1;
			default: mode_ok = 1'b0;
		endcase
	end

	// Effective mode: PCIe uses only the control input
	always_comb
	begin
		if (pcie_cfg)
			eff_mode = pipe_detect_loopback ? TLB_LB_REV_PAR : TLB_LB_NONE;
		else
			eff_mode = mode_reg;
	end

	// ****************************************
	// APB register writes
	// ****************************************

	// Configuration register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_reg <= TLB_CFG_RST;
			gen2_reg <= 1'b0;
		end
		else if (apb_wr && paddr == TLB_OFF_CONFIG && pwdata[1:0] != 2'h3)
		begin
			cfg_reg <= pwdata[1:0];
			gen2_reg <= pwdata[2];
		end
	end

	// Mode register; a new choice replaces the old
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_reg <= TLB_LB_NONE;
		else if (apb_wr && paddr == TLB_OFF_CONFIG && pwdata[1:0] == TLB_CFG_PCIE)
			mode_reg <= TLB_LB_NONE;
		else if (apb_wr && paddr == TLB_OFF_MODE && mode_ok)
			mode_reg <= wmode;
	end

	// Analog settings register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			analog_reg.output_swing_setting <= TLB_SWING_RST;
			analog_reg.pre_emph <= TLB_PRE_RST;
		end
		else if (apb_wr && paddr == TLB_OFF_ANALOG)
		begin
			analog_reg.output_swing_setting <= pwdata[TLB_SWING_W-1:0];
			if (eff_mode != TLB_LB_REV_PRE)
				analog_reg.pre_emph <= pwdata[TLB_PRE_POS+TLB_PRE_W-1:TLB_PRE_POS];
		end
	end

	// ****************************************
	// APB read and response
	// ****************************************

	// Zero wait state response
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable)
			begin
				unique case (paddr)
					TLB_OFF_CONFIG: prdata <= {29'h0, gen2_reg, cfg_reg};
					TLB_OFF_MODE: prdata <= {29'h0, eff_mode};
					TLB_OFF_ANALOG:
						prdata <= {19'h0, analog_reg.pre_emph, 2'h0,
							analog_reg.output_swing_setting};
					TLB_OFF_STATUS:
						prdata <= {29'h0, rx_pcs_in_reset, prbs_error, prbs_locked};
					TLB_OFF_RSTCTL: prdata <= {29'h0, rst_cnt_reg};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// ****************************************
	// Receive PCS reset
	// ****************************************

	// Track last effective mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			eff_prev_reg <= TLB_LB_NONE;
		else
			eff_prev_reg <= eff_mode;
	end

	// Three-cycle reset on each mode change
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rst_cnt_reg <= 3'h0;
		else if (eff_mode != eff_prev_reg)
			rst_cnt_reg <= TLB_RX_RST_LOAD;
		else if (rst_cnt_reg != 3'h0)
			rst_cnt_reg <= rst_cnt_reg - 3'h1;
	end

	assign pcs_rst = rx_pcs_reset | (rst_cnt_reg != 3'h0);

	// Reset status to fabric
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_pcs_in_reset <= 1'b1;
		else
			rx_pcs_in_reset <= pcs_rst;
	end

	// ****************************************
	// Pattern generator and verifier
	// ****************************************

	assign prbs_en = (eff_mode == TLB_LB_FWD_PAR);

	tlb_prbs u_prbs
	(
		.pclk(pclk),
		.presetn(presetn),
		.enable(prbs_en),
		.gen_data(prbs_data),
		.chk_data(rm_reg.data),
		.chk_valid(rm_reg.valid),
		.chk_locked(prbs_locked),
		.chk_error(prbs_error)
	);

	// ****************************************
	// Datapath
	// ****************************************

	// Clock recovery stage input selection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cdr_reg <= '0;
		else
		begin
			cdr_reg.valid <= ~pcs_rst;
			if (eff_mode == TLB_LB_SERIAL)
				cdr_reg.data <= tx_word_reg;
			else if (eff_mode == TLB_LB_FWD_PAR)
				cdr_reg.data <= prbs_data;
			else
				cdr_reg.data <= rx_serial_data;
		end
	end

	// Aligner and rate match stage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rm_reg <= '0;
		else
		begin
			rm_reg.valid <= cdr_reg.valid & ~pcs_rst;
			rm_reg.data <= cdr_reg.data;
		end
	end

	// Fabric receive output
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_parallel_data <= '0;
			rx_data_valid <= 1'b0;
		end
		else
		begin
			rx_parallel_data <= rm_reg.data;
			rx_data_valid <= rm_reg.valid;
		end
	end

	// Serializer word source
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_word_reg <= '0;
		else if (eff_mode == TLB_LB_REV_PAR)
			tx_word_reg <= rm_reg.data;
		else
			tx_word_reg <= tx_parallel_data;
	end

	// Serial output driver
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_serial_data <= '0;
		else
		begin
			unique case (eff_mode)
				TLB_LB_REV_SER: tx_serial_data <= cdr_reg.data;
				TLB_LB_REV_PRE: tx_serial_data <= rx_serial_data;
				default: tx_serial_data <= tx_word_reg;
			endcase
		end
	end

	// Transmit buffer settings out
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			output_swing_setting <= TLB_SWING_RST;
			tx_pre_emphasis <= TLB_PRE_RST;
		end
		else
		begin
			output_swing_setting <= analog_reg.output_swing_setting;
			tx_pre_emphasis <= analog_reg.pre_emph;
		end
	end

endmodule

// *** tlb_pkg.sv ***
// Package with constants and types for the transceiver loopback path selector
package tlb_pkg;

	// ****************************************
	// Register map (word aligned byte offsets)
	// ****************************************
	localparam logic [11:0] TLB_OFF_CONFIG = 12'h000;
	localparam logic [11:0] TLB_OFF_MODE = 12'h004;
	localparam logic [11:0] TLB_OFF_ANALOG = 12'h008;
	localparam logic [11:0] TLB_OFF_STATUS = 12'h00C;
	localparam logic [11:0] TLB_OFF_RSTCTL = 12'h010;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int TLB_SWING_W = 6;
	localparam int TLB_PRE_W = 5;
	localparam int TLB_DATA_W = 20;
	localparam int TLB_PRE_POS = 8;
	localparam int TLB_MODE_W = 3;
	localparam logic [TLB_SWING_W-1:0] TLB_SWING_RST = 6'h20;
	localparam logic [TLB_PRE_W-1:0] TLB_PRE_RST = 5'h00;
	localparam logic [1:0] TLB_CFG_RST = 2'h0;

	// ****************************************
	// Timing: receive PCS reset length
	// ****************************************
	localparam int TLB_RX_RST_CYCLES = 2;
	localparam logic [2:0] TLB_RX_RST_LOAD = 3'(TLB_RX_RST_CYCLES + 1);

	// Channel configuration
	typedef enum logic [1:0]
	{
		TLB_CFG_GENERIC = 2'h0,
		TLB_CFG_PROTO = 2'h1,
		TLB_CFG_PCIE = 2'h2
	} tlb_cfg_t;

	// Loopback path selection, one at a time
	typedef enum logic [2:0]
	{
		TLB_LB_NONE = 3'h0,
		TLB_LB_SERIAL = 3'h1,
		TLB_LB_FWD_PAR = 3'h2,
		TLB_LB_REV_PAR = 3'h3,
		TLB_LB_REV_SER = 3'h4,
		TLB_LB_REV_PRE = 3'h5
	} tlb_mode_t;

	// Analog transmit buffer settings
	typedef struct packed
	{
		logic [TLB_PRE_W-1:0] pre_emph;
		logic [TLB_SWING_W-1:0] output_swing_setting;
	} tlb_analog_t;

	// Receive word with status
	typedef struct packed
	{
		logic valid;
		logic [TLB_DATA_W-1:0] data;
	} tlb_word_t;

endpackage

// *** tlb_prbs.sv ***
// Pattern generator and verifier sharing one polynomial (x^7 + x^6 + 1)
`timescale 1ns/1ps
module tlb_prbs
	import tlb_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic enable,
	// Generator output
	output logic [TLB_DATA_W-1:0] gen_data,
	// Verifier input and status
	input wire logic [TLB_DATA_W-1:0] chk_data,
	input wire logic chk_valid,
	output logic chk_locked,
	output logic chk_error
);

	// Generator state
	logic [6:0] gen_reg;
	// Verifier state
	logic [6:0] chk_reg;
	logic [2:0] good_reg;

	// Next word of the sequence
	function automatic logic [6:0] prbs_step(input logic [6:0] s);
		logic [6:0] r;
		r = s;
		for (int i = 0; i < 7; i++)
		begin
			r = {r[5:0], r[6] ^ r[5]};
		end
		return r;
	endfunction

	// Replicate seed across the word
	function automatic logic [TLB_DATA_W-1:0] prbs_word(input logic [6:0] s);
		logic [TLB_DATA_W-1:0] w;
		w = '0;
		for (int i = 0; i < TLB_DATA_W; i++)
		begin
			w[i] = s[i % 7];
		end
		return w;
	endfunction

	// Generator advances each cycle while enabled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			gen_reg <= 7'h7F;
		else if (enable)
			gen_reg <= prbs_step(gen_reg);
	end

	// Registered generator output
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			gen_data <= '0;
		else
			gen_data <= enable ? prbs_word(gen_reg) : '0;
	end

	// Verifier seeds from the incoming word, then compares
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			chk_reg <= 7'h00;
			good_reg <= 3'h0;
			chk_locked <= 1'b0;
			chk_error <= 1'b0;
		end
		else if (!enable)
		begin
			good_reg <= 3'h0;
			chk_locked <= 1'b0;
			chk_error <= 1'b0;
		end
		else if (chk_valid)
		begin
			chk_reg <= prbs_step(chk_data[6:0]);
			if (chk_data == prbs_word(chk_reg))
			begin
				if (good_reg != 3'h7)
					good_reg <= good_reg + 3'h1;
				chk_locked <= (good_reg == 3'h7);
			end
			else
			begin
				// Sticky error only once locked
				chk_error <= chk_error | chk_locked;
				good_reg <= 3'h0;
				chk_locked <= 1'b0;
			end
		end
	end

endmodule

// *** tlb_top_sva.sv ***
// Checker for the loopback selector: APB handshake, receive reset, swing source
`timescale 1ns/1ps
module tlb_top_sva
	import tlb_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// Receive side and analog
	input wire logic rx_data_valid,
	input wire logic rx_pcs_in_reset,
	input wire logic [TLB_SWING_W-1:0] output_swing_setting
);
	// One clock domain for every property
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Answer is a single cycle pulse
	property p_pready_pulse;
		pready |=> !pready;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");
	// Zero wait answer after setup
	property p_pready_setup;
		psel && !penable |=> pready;
	endproperty
	a_pready_setup: assert property (p_pready_setup) else $error("no answer after setup");
	// Answer only inside an access phase
	property p_pready_phase;
		pready |-> psel && penable;
	endproperty
	a_pready_phase: assert property (p_pready_phase) else $error("pready outside access");
	// Error flag only with the answer
	property p_err_pulse;
		pslverr |-> pready;
	endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("pslverr without pready");
	// Address above the map answers with error
	property p_err_unmapped;
		pready && paddr > TLB_OFF_RSTCTL |-> pslverr;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped without error");
	// Mapped address answers cleanly
	property p_err_mapped;
		pready && paddr <= TLB_OFF_RSTCTL && paddr[1:0] == 2'h0 |-> !pslverr;
	endproperty
	a_err_mapped: assert property (p_err_mapped) else $error("mapped access flagged");
	// Receive reset lasts two cycles or more
	property p_rst_hold;
		$rose(rx_pcs_in_reset) |=> rx_pcs_in_reset;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("receive reset too short");
	// No valid words from the second cycle of receive reset on
	property p_valid_off;
		rx_pcs_in_reset [*2] |-> !rx_data_valid;
	endproperty
	a_valid_off: assert property (p_valid_off) else $error("valid during receive reset");
	// Swing only moves two edges after an analog register write (register, then output)
	property p_swing_src;
		$changed(output_swing_setting) |-> $past(psel, 2) && $past(pwrite, 2)
			&& $past(penable, 2) && $past(paddr, 2) == TLB_OFF_ANALOG;
	endproperty
	a_swing_src: assert property (p_swing_src) else $error("swing changed without write");
endmodule

// *** tlb_link_partner.sv ***
// Far end link partner: drives a new serial word every cycle
`timescale 1ns/1ps
module tlb_link_partner
	import tlb_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Serial pins seen from the far side
	input wire logic [TLB_DATA_W-1:0] tx_serial_data,
	output logic [TLB_DATA_W-1:0] rx_serial_data
);
	// Word steps each cycle so a wrong latency never matches
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_serial_data <= 20'h5A3C1;
		else
			rx_serial_data <= rx_serial_data + 20'h1357B;
	end
endmodule

// *** tlb_top_bench.sv ***
// Self-checking bench for the loopback selector over APB
`timescale 1ns/1ps
module tlb_top_bench
	import tlb_pkg::*;
;
	// ****************************************
	// Signals
	// ****************************************
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [TLB_DATA_W-1:0] tx_parallel_data, rx_parallel_data, rx_serial_data, tx_serial_data;
	logic pipe_detect_loopback, rx_pcs_reset, rx_data_valid, rx_pcs_in_reset;
	logic [TLB_SWING_W-1:0] output_swing_setting;
	logic [TLB_PRE_W-1:0] tx_pre_emphasis;
	logic [2:0] ml [4] = '{3'h1, 3'h2, 3'h4, 3'h5};
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;

	tlb_top dut
	(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.tx_parallel_data(tx_parallel_data),
		.pipe_detect_loopback(pipe_detect_loopback),
		.rx_pcs_reset(rx_pcs_reset),
		.rx_parallel_data(rx_parallel_data),
		.rx_data_valid(rx_data_valid),
		.rx_pcs_in_reset(rx_pcs_in_reset),
		.rx_serial_data(rx_serial_data),
		.tx_serial_data(tx_serial_data),
		.output_swing_setting(output_swing_setting),
		.tx_pre_emphasis(tx_pre_emphasis)
	);
	tlb_link_partner partner
	(
		.pclk(pclk),
		.presetn(presetn),
		.tx_serial_data(tx_serial_data),
		.rx_serial_data(rx_serial_data)
	);

	// Clock of 20 ns
	initial
	begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task stop_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task w(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One APB transfer, held until pready
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(rdat, e);
	endtask
	// Fabric pulse of the receive reset, two cycles
	task rx_rst;
		@(posedge pclk);
		rx_pcs_reset <= 1'h1;
		w(2);
		rx_pcs_reset <= 1'h0;
		w(8);
	endtask
	// Serial word returns after lat cycles, reaches fabric after three
	task lat_chk(input int lat);
		logic [TLB_DATA_W-1:0] x;
		@(posedge pclk);
		#1 x = rx_serial_data;
		repeat (lat) @(posedge pclk);
		#1 chk(32'(tx_serial_data), 32'(x));
		if (lat < 3)
		begin
			repeat (3 - lat) @(posedge pclk);
			// Fabric still fed
			#1 chk(32'({rx_data_valid, rx_parallel_data}), 32'({1'h1, x}));
		end
	endtask

	// Hang guard
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_mismatch++;
			$display("ERROR at %0t: timeout", $time);
			stop_test;
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pipe_detect_loopback = 1'h0;
		rx_pcs_reset = 1'h0;
		tx_parallel_data = 20'hA5C3F;
		w(8);
		presetn <= 1'h1;
		rd(TLB_OFF_CONFIG, 32'h0);
		rd(TLB_OFF_MODE, 32'h0);
		rd(TLB_OFF_ANALOG, 32'h20);
		rd(12'h014, 32'h0);
		chk(32'(perr), 32'h1);
		$display("reset test done");
		wr(TLB_OFF_CONFIG, 32'h1);
		wr(TLB_OFF_MODE, 32'h1);
		rx_rst;
		rd(TLB_OFF_MODE, 32'h1);
		wr(TLB_OFF_MODE, 32'h2);
		rd(TLB_OFF_MODE, 32'h1);
		chk(32'(tx_serial_data), 32'h0A5C3F);
		chk(32'({rx_data_valid, rx_parallel_data}), 32'h1A5C3F);
		wr(TLB_OFF_MODE, 32'h0);
		rx_rst;
		rd(TLB_OFF_MODE, 32'h0);
		$display("serial loopback test done");
		wr(TLB_OFF_CONFIG, 32'h0);
		wr(TLB_OFF_MODE, 32'h5);
		w(8);
		lat_chk(1);
		wr(TLB_OFF_ANALOG, 32'h0A15);
		rd(TLB_OFF_ANALOG, 32'h0015);
		chk(32'({tx_pre_emphasis, output_swing_setting}), 32'h15);
		wr(TLB_OFF_MODE, 32'h4);
		w(8);
		lat_chk(2);
		wr(TLB_OFF_ANALOG, 32'h0A15);
		rd(TLB_OFF_ANALOG, 32'h0A15);
		chk(32'(tx_pre_emphasis), 32'h0A);
		$display("reverse serial test done");
		wr(TLB_OFF_MODE, 32'h2);
		rx_rst;
		w(40);
		wr(TLB_OFF_MODE, 32'h3);
		rd(TLB_OFF_MODE, 32'h2);
		rd(TLB_OFF_STATUS, 32'h1);
		$display("forward parallel test done");
		wr(TLB_OFF_CONFIG, 32'h2);
		rd(TLB_OFF_MODE, 32'h0);
		foreach (ml[i])
		begin
			wr(TLB_OFF_MODE, 32'(ml[i]));
			rd(TLB_OFF_MODE, 32'h0);
		end
		pipe_detect_loopback <= 1'h1;
		w(8);
		rd(TLB_OFF_MODE, 32'h3);
		lat_chk(4);
		pipe_detect_loopback <= 1'h0;
		w(8);
		rd(TLB_OFF_MODE, 32'h0);
		// Mode writes made while in PCIe must not have landed
		wr(TLB_OFF_CONFIG, 32'h0);
		rd(TLB_OFF_MODE, 32'h0);
		$display("pcie test done");
		stop_test;
	end
endmodule

bind tlb_top tlb_top_sva chk_sva
(
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pready(pready),
	.pslverr(pslverr),
	.rx_data_valid(rx_data_valid),
	.rx_pcs_in_reset(rx_pcs_in_reset),
	.output_swing_setting(output_swing_setting)
);
